// ==== include/asrs_cfg.svh ====
`ifndef ASRS_CFG_SVH
`define ASRS_CFG_SVH

// register offsets
`define ASRS_A_STATUS     8'h00
`define ASRS_A_XH         8'h01
`define ASRS_A_XL         8'h02
`define ASRS_A_YH         8'h03
`define ASRS_A_YL         8'h04
`define ASRS_A_ZH         8'h05
`define ASRS_A_ZL         8'h06
`define ASRS_A_MODE       8'h0b
`define ASRS_A_SUMMARY    8'h0c
`define ASRS_A_ORIENT_SRC 8'h10
`define ASRS_A_FFMT_SRC   8'h16
`define ASRS_A_TRANS_SRC  8'h1e
`define ASRS_A_PULSE_SRC  8'h22
`define ASRS_A_STEP       8'h01

// operating mode codes
`define ASRS_MODE_STANDBY 2'h0
`define ASRS_MODE_WAKE    2'h1
`define ASRS_MODE_SLEEP   2'h2
`define ASRS_MODE_UNUSED  2'h3

// summary bit positions
`define ASRS_B_SLEEP      7
`define ASRS_B_TRANS      5
`define ASRS_B_ORIENT     4
`define ASRS_B_PULSE      3
`define ASRS_B_FFMT       2
`define ASRS_B_DRDY       0

// serial port
`define ASRS_DEV_ADDR     7'h1c
`define ASRS_BYTE_BITS    4'h8
`define ASRS_CNT_STEP     4'h1
`define ASRS_NIB_ZERO     4'h0
`define ASRS_MODE_PAD     6'h00
`define ASRS_BYTE_ZERO    8'h00

`endif

// ==== include/asrs_pkg.sv ====
`default_nettype none

package asrs_pkg;

  typedef enum logic [2:0] {
    ASRS_IDLE    = 3'b000,
    ASRS_DEVADDR = 3'b001,
    ASRS_DEVACK  = 3'b010,
    ASRS_REGADDR = 3'b011,
    ASRS_REGACK  = 3'b100,
    ASRS_WRBYTE  = 3'b101,
    ASRS_TXBYTE  = 3'b110,
    ASRS_TXACK   = 3'b111
  } asrs_port_t;

endpackage
`default_nettype wire

// ==== rtl/asrs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module asrs_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // two flops, first one read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '1;
      dout   <= '1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/asrs_axis_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "asrs_cfg.svh"

module asrs_axis_reg (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        clr,
  input  wire logic        highRead,
  // sample in
  input  wire logic        sampleValid,
  input  wire logic [11:0] sampleIn,
  // flags and bytes
  output logic             ready,
  output logic             overwrite,
  output logic      [7:0]  highByte,
  output logic      [7:0]  lowShadow
);

  logic [11:0] sample;

  assign highByte = sample[11:4];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready     <= 1'b0;
      overwrite <= 1'b0;
    end else begin
      ready     <= sampleValid | (ready & ~highRead & ~clr);
      overwrite <= (sampleValid & ready & ~clr) | (overwrite & ~highRead & ~clr);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample    <= '0;
      lowShadow <= '0;
    end else begin
      if (sampleValid) begin
        sample <= sampleIn;
      end else if (clr) begin
        sample <= '0;
      end
      if (clr) begin
        lowShadow <= '0;
      end else if (highRead) begin
        lowShadow <= {sample[3:0], `ASRS_NIB_ZERO};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence hiTaken;
    highRead && !clr;
  endsequence

  property lowFromSame;
    logic [3:0] nib;
    (hiTaken, nib = sample[3:0]) |=> lowShadow == {nib, `ASRS_NIB_ZERO};
  endproperty

  low_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_n) lowFromSame)
    else $error("low byte not taken from the sample read high");

  rdy_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    highRead && !sampleValid |=> !ready)
    else $error("ready not cleared by high read");

  ow_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sampleValid && ready && !clr |=> overwrite && ready)
    else $error("overwrite not set on unread sample");

  ow_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    highRead && !sampleValid |=> !overwrite)
    else $error("overwrite not cleared by high read");

endmodule
`default_nettype wire

// ==== rtl/asrs_readout.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "asrs_cfg.svh"

module asrs_readout
  import asrs_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // serial port pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // sample engine
  input  wire logic        xValid,
  input  wire logic [11:0] xSample,
  input  wire logic        yValid,
  input  wire logic [11:0] ySample,
  input  wire logic        zValid,
  input  wire logic [11:0] zSample,
  // control
  input  wire logic [2:0]  axisEnable,
  input  wire logic        fastRead,
  input  wire logic        drdyIntEnable,
  input  wire logic [1:0]  modeCode,
  // function interrupts
  input  wire logic        ffMtIrq,
  input  wire logic        pulseIrq,
  input  wire logic        orientIrq,
  input  wire logic        transIrq,
  input  wire logic        sleepWakeIrq
);

  asrs_port_t  state;
  asrs_port_t  next_state;
  logic        sclS;
  logic        sdaS;
  logic        sclPrev;
  logic        sdaPrev;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftIn;
  logic [7:0]  shiftOut;
  logic [7:0]  next_shiftOut;
  logic [7:0]  ptr;
  logic [7:0]  lastAddr;
  logic        lastValid;
  logic        isRead;
  logic        ackOk;
  logic        next_sdaOe;
  logic [1:0]  modeReg;
  logic        allReady;
  logic        allOw;
  logic [5:0]  summ;
  logic [5:0]  irqPrev;
  logic [2:0]  readyVec;
  logic [2:0]  owVec;
  logic [7:0]  xHigh;
  logic [7:0]  yHigh;
  logic [7:0]  zHigh;
  logic [7:0]  xLow;
  logic [7:0]  yLow;
  logic [7:0]  zLow;
  logic [7:0]  summaryByte;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus conditions
  asrs_sync #(.W(2)) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     ({sclIn, sdaIn}),
    .dout    ({sclS, sdaS})
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  wire sclRise   = sclS & ~sclPrev;
  wire sclFall   = ~sclS & sclPrev;
  wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;
  wire byteDone  = bitCnt == `ASRS_BYTE_BITS;
  wire addrHit   = shiftIn[7:1] == `ASRS_DEV_ADDR;
  wire txLoad    = sclFall & (((state == ASRS_DEVACK) & isRead)
                   | ((state == ASRS_TXACK) & ackOk));
  wire regLoad   = sclFall & byteDone & (state == ASRS_REGADDR);

  ////////////////////////////////////////////////////////////////////
  // read decode and side effects
  wire rdXh     = txLoad & (ptr == `ASRS_A_XH);
  wire rdYh     = txLoad & (ptr == `ASRS_A_YH);
  wire rdZh     = txLoad & (ptr == `ASRS_A_ZH);
  wire rdStatus = txLoad & (ptr == `ASRS_A_STATUS);
  wire rdMode   = txLoad & (ptr == `ASRS_A_MODE);
  wire rdOrient = txLoad & (ptr == `ASRS_A_ORIENT_SRC);
  wire rdFfmt   = txLoad & (ptr == `ASRS_A_FFMT_SRC);
  wire rdTrans  = txLoad & (ptr == `ASRS_A_TRANS_SRC);
  wire rdPulse  = txLoad & (ptr == `ASRS_A_PULSE_SRC);
  wire lowOkX   = lastValid & (lastAddr == `ASRS_A_XH);
  wire lowOkY   = lastValid & (lastAddr == `ASRS_A_YH);
  wire lowOkZ   = lastValid & (lastAddr == `ASRS_A_ZH);

  wire actStart = (modeReg == `ASRS_MODE_STANDBY)
                  & ((modeCode == `ASRS_MODE_WAKE) | (modeCode == `ASRS_MODE_SLEEP));

  wire [2:0] validVec  = {zValid, yValid, xValid};
  wire [2:0] hiRdVec   = {rdZh, rdYh, rdXh};
  wire [2:0] readyNext = (readyVec & ~hiRdVec) | validVec;
  wire       newAny    = |(validVec & axisEnable);
  wire       owAny     = |(validVec & readyVec);
  wire       allClear  = (|hiRdVec) & ~(|(readyNext & axisEnable));
  wire [7:0] statusByte = {allOw, owVec, allReady, readyVec};
  wire [7:0] modeByte   = {`ASRS_MODE_PAD, modeReg};

  wire [7:0] rdByte =
    (ptr == `ASRS_A_STATUS)           ? statusByte  :
    (ptr == `ASRS_A_XH)               ? xHigh       :
    ((ptr == `ASRS_A_XL) && lowOkX)   ? xLow        :
    (ptr == `ASRS_A_YH)               ? yHigh       :
    ((ptr == `ASRS_A_YL) && lowOkY)   ? yLow        :
    (ptr == `ASRS_A_ZH)               ? zHigh       :
    ((ptr == `ASRS_A_ZL) && lowOkZ)   ? zLow        :
    (ptr == `ASRS_A_MODE)             ? modeByte    :
    (ptr == `ASRS_A_SUMMARY)          ? summaryByte : `ASRS_BYTE_ZERO;

  // burst wrap after last sample byte
  wire [7:0] nextPtr =
    (ptr == `ASRS_A_ZL)                ? `ASRS_A_STATUS :
    (fastRead && ptr == `ASRS_A_XH)    ? `ASRS_A_YH     :
    (fastRead && ptr == `ASRS_A_YH)    ? `ASRS_A_ZH     :
    (fastRead && ptr == `ASRS_A_ZH)    ? `ASRS_A_STATUS : 8'(ptr + `ASRS_A_STEP);

  ////////////////////////////////////////////////////////////////////
  // axis holders
  asrs_axis_reg uAxisX (
    .sys_clk (sys_clk), .rst_n (rst_n), .clr (actStart), .highRead (rdXh),
    .sampleValid (xValid), .sampleIn (xSample),
    .ready (readyVec[0]), .overwrite (owVec[0]), .highByte (xHigh), .lowShadow (xLow)
  );
  asrs_axis_reg uAxisY (
    .sys_clk (sys_clk), .rst_n (rst_n), .clr (actStart), .highRead (rdYh),
    .sampleValid (yValid), .sampleIn (ySample),
    .ready (readyVec[1]), .overwrite (owVec[1]), .highByte (yHigh), .lowShadow (yLow)
  );
  asrs_axis_reg uAxisZ (
    .sys_clk (sys_clk), .rst_n (rst_n), .clr (actStart), .highRead (rdZh),
    .sampleValid (zValid), .sampleIn (zSample),
    .ready (readyVec[2]), .overwrite (owVec[2]), .highByte (zHigh), .lowShadow (zLow)
  );

  ////////////////////////////////////////////////////////////////////
  // port state machine
  always_comb begin
    next_state = state;
    case (state)
      ASRS_IDLE: begin
        next_state = ASRS_IDLE;
      end
      ASRS_DEVADDR: begin
        if (sclFall && byteDone) next_state = addrHit ? ASRS_DEVACK : ASRS_IDLE;
      end
      ASRS_DEVACK: begin
        if (sclFall) next_state = isRead ? ASRS_TXBYTE : ASRS_REGADDR;
      end
      ASRS_REGADDR, ASRS_WRBYTE: begin
        if (sclFall && byteDone) next_state = ASRS_REGACK;
      end
      ASRS_REGACK: begin
        if (sclFall) next_state = ASRS_WRBYTE;
      end
      ASRS_TXBYTE: begin
        if (sclFall && byteDone) next_state = ASRS_TXACK;
      end
      ASRS_TXACK: begin
        if (sclFall) next_state = ackOk ? ASRS_TXBYTE : ASRS_IDLE;
      end
      default: begin
        next_state = ASRS_IDLE;
      end
    endcase
    if (startSeen) next_state = ASRS_DEVADDR;
    if (stopSeen) next_state = ASRS_IDLE;
  end

  assign next_shiftOut = txLoad ? rdByte :
                         (sclFall && state == ASRS_TXBYTE) ? {shiftOut[6:0], 1'b0} : shiftOut;
  assign next_sdaOe    = (next_state == ASRS_DEVACK) | (next_state == ASRS_REGACK)
                         | ((next_state == ASRS_TXBYTE) & ~next_shiftOut[7]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ASRS_IDLE;
      shiftOut <= '0;
      sdaOe    <= 1'b0;
      sdaOut   <= 1'b0;
    end else begin
      state    <= next_state;
      shiftOut <= next_shiftOut;
      sdaOe    <= next_sdaOe;
      sdaOut   <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt  <= '0;
      shiftIn <= '0;
      isRead  <= 1'b0;
      ackOk   <= 1'b0;
    end else begin
      if (next_state != state) begin
        bitCnt <= '0;
      end else if (sclRise) begin
        bitCnt <= bitCnt + `ASRS_CNT_STEP;
      end
      if (sclRise) shiftIn <= {shiftIn[6:0], sdaS};
      if (sclFall && byteDone && state == ASRS_DEVADDR) isRead <= shiftIn[0];
      if (sclRise && state == ASRS_TXACK) ackOk <= ~sdaS;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr       <= `ASRS_A_STATUS;
      lastAddr  <= `ASRS_A_STATUS;
      lastValid <= 1'b0;
    end else if (stopSeen) begin
      ptr       <= `ASRS_A_STATUS;
      lastValid <= 1'b0;
    end else if (regLoad) begin
      ptr       <= shiftIn;
      lastValid <= 1'b0;
    end else if (txLoad) begin
      ptr       <= nextPtr;
      lastAddr  <= ptr;
      lastValid <= 1'b1;
    end else if (startSeen) begin
      lastValid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // combined flags, mode and summary
  // unused mode code ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= `ASRS_MODE_STANDBY;
    end else if (modeCode != `ASRS_MODE_UNUSED) begin
      modeReg <= modeCode;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      allReady <= 1'b0;
      allOw    <= 1'b0;
    end else begin
      allReady <= newAny | (allReady & ~allClear & ~actStart);
      allOw    <= owAny | (allOw & ~allClear & ~actStart);
    end
  end

  wire       drdyLvl = (allReady | allOw) & drdyIntEnable;
  wire [5:0] irqVec  = {sleepWakeIrq, transIrq, orientIrq, pulseIrq, ffMtIrq, drdyLvl};
  // data bit cleared by sample reads and by activation only
  // sleep bit cleared by mode read
  wire [5:0] clrVec  = {rdMode, rdTrans, rdOrient, rdPulse, rdFfmt, allClear};
  wire [5:0] riseVec = irqVec & ~irqPrev;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      summ    <= '0;
      irqPrev <= '0;
    end else begin
      irqPrev <= irqVec;
      summ    <= riseVec | (summ & ~clrVec & {6{~actStart}});
    end
  end

  always_comb begin
    summaryByte                 = `ASRS_BYTE_ZERO;
    summaryByte[`ASRS_B_SLEEP]  = summ[5];
    summaryByte[`ASRS_B_TRANS]  = summ[4];
    summaryByte[`ASRS_B_ORIENT] = summ[3];
    summaryByte[`ASRS_B_PULSE]  = summ[2];
    summaryByte[`ASRS_B_FFMT]   = summ[1];
    summaryByte[`ASRS_B_DRDY]   = summ[0];
  end

  ////////////////////////////////////////////////////////////////////
  ready_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xValid |=> readyVec[0] && statusByte[0])
    else $error("x ready flag not set by new sample");

  comb_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(validVec & axisEnable) |=> allReady)
    else $error("combined ready not set");

  comb_ow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    owAny |=> allOw && statusByte[7])
    else $error("combined overwrite not set");

  act_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    actStart && validVec == 3'h0 && riseVec == 6'h00 |=> statusByte == 8'h00 && summ == 6'h00)
    else $error("flags not cleared on activation");

  burst_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txLoad && !fastRead && ptr == `ASRS_A_XH |=> ptr == `ASRS_A_XL)
    else $error("burst did not step to x low byte");

  fast_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txLoad && fastRead && ptr == `ASRS_A_XH |=> ptr == `ASRS_A_YH)
    else $error("fast read did not skip x low byte");

  low_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    txLoad && ptr == `ASRS_A_XL && !lowOkX |=> shiftOut == 8'h00)
    else $error("random low byte read not zero");

  mode_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    modeReg != `ASRS_MODE_UNUSED && modeByte[7:2] == 6'h00)
    else $error("mode field holds unused code");

  stop_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stopSeen |=> ptr == `ASRS_A_STATUS && !lastValid)
    else $error("pointer not cleared by stop");

  summ_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pulseIrq) |=> ##1 summaryByte[`ASRS_B_PULSE])
    else $error("pulse summary bit not set on rise");

  aslp_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdMode && !riseVec[5] |=> !summaryByte[`ASRS_B_SLEEP])
    else $error("sleep summary bit not cleared by mode read");

  drdy_stay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdStatus && summ[0] && !actStart |=> summ[0])
    else $error("status read cleared data summary bit");

endmodule
`default_nettype wire

// ==== verif/asrs_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "asrs_cfg.svh"

module asrs_host_model (
  // clock
  input  wire logic sys_clk,
  // device data drive
  input  wire logic sdaOe,
  // bus lines
  output logic      sclLine,
  output logic      sdaLine
);
  logic sdaPull = 1'b0;

  initial sclLine = 1'b1;

  // open drain with pull-up
  assign sdaLine = ~(sdaPull | sdaOe);

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic put_bit(input logic b, output logic s);
    tick(4);
    sdaPull <= ~b;
    tick(4);
    sclLine <= 1'b1;
    tick(8);
    s = sdaLine;
    sclLine <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, input logic ackIn,
                          output logic [7:0] r, output logic ackOut);
    for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
    put_bit(ackIn, ackOut);
  endtask

  task automatic start_cond();
    tick(4);
    sdaPull <= 1'b0;
    tick(4);
    sclLine <= 1'b1;
    tick(8);
    sdaPull <= 1'b1;
    tick(8);
    sclLine <= 1'b0;
  endtask

  task automatic stop_cond();
    tick(4);
    sdaPull <= 1'b1;
    tick(4);
    sclLine <= 1'b1;
    tick(8);
    sdaPull <= 1'b0;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic read_regs(input logic usePtr, input logic [7:0] ptr, input int n,
                           output logic [7:0] q [8], output logic ackOk);
    logic [7:0] junk;
    logic       a;
    ackOk = 1'b1;
    if (usePtr) begin
      start_cond();
      put_byte({`ASRS_DEV_ADDR, 1'b0}, 1'b1, junk, a);
      ackOk &= ~a;
      put_byte(ptr, 1'b1, junk, a);
      ackOk &= ~a;
    end
    start_cond();
    put_byte({`ASRS_DEV_ADDR, 1'b1}, 1'b1, junk, a);
    ackOk &= ~a;
    // bytes taken in burst order, last one refused
    for (int k = 0; k < n; k++) put_byte(8'hff, (k == n - 1), q[k], a);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ==== verif/test_asrs_readout.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_asrs_readout;
  logic        sys_clk       = 1'b0;
  logic        rst_n         = 1'b0;
  logic [2:0]  valids        = 3'h0;
  logic [11:0] xSample       = 12'h000;
  logic [11:0] ySample       = 12'h000;
  logic [11:0] zSample       = 12'h000;
  logic [2:0]  axisEnable    = 3'h7;
  logic        fastRead      = 1'b0;
  logic        drdyIntEnable = 1'b1;
  logic [1:0]  modeCode      = 2'h0;
  logic [4:0]  irqs          = 5'h00;
  wire logic   sclLine;
  wire logic   sdaLine;
  wire logic   sdaOe;
  wire logic   sdaOut;
  int          nMismatch     = 0;
  int          checked       = 0;
  logic [7:0]  q [8];
  logic        ackOk;

  always #5 sys_clk = ~sys_clk;

  asrs_readout DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe),
    .xValid(valids[0]), .xSample(xSample), .yValid(valids[1]), .ySample(ySample),
    .zValid(valids[2]), .zSample(zSample),
    .axisEnable(axisEnable), .fastRead(fastRead), .drdyIntEnable(drdyIntEnable),
    .modeCode(modeCode),
    .ffMtIrq(irqs[0]), .pulseIrq(irqs[1]), .orientIrq(irqs[2]), .transIrq(irqs[3]),
    .sleepWakeIrq(irqs[4])
  );

  asrs_host_model host (.sys_clk(sys_clk), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      nMismatch++;
    end
  endtask

  task automatic rd(input logic [7:0] ptr, input int n);
    host.read_regs(1'b1, ptr, n, q, ackOk);
    check8("ack", 8'h01, {7'h00, ackOk});
  endtask

  task automatic push(input logic [2:0] m, input logic [11:0] x, y, z);
    @(posedge sys_clk);
    valids <= m;
    xSample <= x;
    ySample <= y;
    zSample <= z;
    @(posedge sys_clk);
    valids <= 3'h0;
  endtask

  task automatic set_ctl(input logic [1:0] m, input logic [4:0] v, input logic f);
    @(posedge sys_clk);
    modeCode <= m;
    irqs <= v;
    fastRead <= f;
    repeat (3) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(8'h00, 1);
    check8("status", 8'h00, q[0]);
    check8("drive", 8'h00, {7'h00, sdaOut});
    rd(8'h0b, 2);
    check8("mode", 8'h00, q[0]);
    check8("summary", 8'h00, q[1]);
    set_ctl(2'h1, 5'h00, 1'b0);
    $display("test_reset done");
  endtask

  task automatic test_burst();
    logic [7:0] exp [7] = '{8'h0f, 8'h12, 8'h30, 8'hab, 8'hc0, 8'h80, 8'h50};
    push(3'h7, 12'h123, 12'habc, 12'h805);
    rd(8'h0c, 1);
    check8("summary", 8'h01, q[0]);
    rd(8'h00, 1);
    check8("status", 8'h0f, q[0]);
    rd(8'h0c, 1);
    check8("summary", 8'h01, q[0]);
    rd(8'h00, 7);
    for (int i = 0; i < 7; i++) check8("burst", exp[i], q[i]);
    rd(8'h00, 1);
    check8("status", 8'h00, q[0]);
    rd(8'h0c, 1);
    check8("summary", 8'h00, q[0]);
    $display("test_burst done");
  endtask

  task automatic test_overwrite();
    logic [7:0] exp [6] = '{8'h7f, 8'hf0, 8'h80, 8'h00, 8'hff, 8'hf0};
    push(3'h3, 12'h111, 12'h222, 12'h000);
    push(3'h7, 12'h7ff, 12'h800, 12'hfff);
    rd(8'h0b, 1);
    check8("mode", 8'h01, q[0]);
    host.read_regs(1'b0, 8'h00, 1, q, ackOk);
    check8("ack", 8'h01, {7'h00, ackOk});
    check8("status", 8'hbf, q[0]);
    rd(8'h01, 6);
    for (int i = 0; i < 6; i++) check8("sample", exp[i], q[i]);
    rd(8'h00, 1);
    check8("status", 8'h00, q[0]);
    $display("test_overwrite done");
  endtask

  task automatic test_fast();
    logic [7:0] exp [5] = '{8'h0f, 8'h9a, 8'h3c, 8'h5e, 8'h00};
    set_ctl(2'h1, 5'h00, 1'b1);
    push(3'h7, 12'h9a5, 12'h3c6, 12'h5e7);
    rd(8'h00, 5);
    for (int i = 0; i < 5; i++) check8("burst", exp[i], q[i]);
    set_ctl(2'h1, 5'h00, 1'b0);
    $display("test_fast done");
  endtask

  task automatic test_lock();
    push(3'h1, 12'h456, 12'h000, 12'h000);
    fork
      rd(8'h01, 2);
      begin
        repeat (550) @(posedge sys_clk);
        push(3'h1, 12'h89a, 12'h000, 12'h000);
      end
    join
    check8("high", 8'h45, q[0]);
    check8("low", 8'h60, q[1]);
    rd(8'h02, 1);
    check8("low", 8'h00, q[0]);
    rd(8'h01, 2);
    check8("high", 8'h89, q[0]);
    check8("low", 8'ha0, q[1]);
    axisEnable <= 3'h1;
    push(3'h2, 12'h000, 12'h4d0, 12'h000);
    rd(8'h00, 4);
    check8("status", 8'h02, q[0]);
    check8("high", 8'h4d, q[3]);
    axisEnable <= 3'h7;
    $display("test_lock done");
  endtask

  task automatic test_mode();
    logic [7:0] src [4] = '{8'h16, 8'h22, 8'h10, 8'h1e};
    logic [7:0] exp [4] = '{8'h38, 8'h30, 8'h20, 8'h00};
    set_ctl(2'h2, 5'h00, 1'b0);
    rd(8'h0b, 1);
    check8("mode", 8'h02, q[0]);
    set_ctl(2'h3, 5'h10, 1'b0);
    rd(8'h0c, 1);
    check8("summary", 8'h80, q[0]);
    rd(8'h0b, 1);
    check8("mode", 8'h02, q[0]);
    rd(8'h0c, 1);
    check8("summary", 8'h00, q[0]);
    set_ctl(2'h2, 5'h1f, 1'b0);
    rd(8'h0c, 1);
    check8("summary", 8'h3c, q[0]);
    for (int i = 0; i < 4; i++) begin
      rd(src[i], 1);
      rd(8'h0c, 1);
      check8("summary", exp[i], q[0]);
    end
    set_ctl(2'h0, 5'h00, 1'b0);
    push(3'h7, 12'h321, 12'h654, 12'h987);
    set_ctl(2'h1, 5'h00, 1'b0);
    rd(8'h00, 2);
    check8("status", 8'h00, q[0]);
    check8("high", 8'h00, q[1]);
    $display("test_mode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    test_reset();
    test_burst();
    test_overwrite();
    test_fast();
    test_lock();
    test_mode();
    finish_test();
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    $display("unexpected run time expected done seen hang");
    nMismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
